// File: fsag_consts.svh
// Purpose: Constants of the flash section access guard
// Assumes: Word-addressed program flash, AHB-Lite register window
// Notes:   Offsets are byte addresses within the slave window
`ifndef FSAG_CONSTS_SVH
`define FSAG_CONSTS_SVH

// Flash word address width and region limits
`define FSAG_AW         12
`define FSAG_HALT_BASE  12'hc00
`define FSAG_BOOT_MIN   12'h080

// Register offsets
`define FSAG_OFS_CTRL   8'h00
`define FSAG_OFS_STAT   8'h04

// Control register fields
`define FSAG_CTRL_REEN  0
`define FSAG_CTRL_VECB  1
`define FSAG_CTRL_RST   1'h0

// Status register fields
`define FSAG_STAT_BUSY  0
`define FSAG_STAT_STALL 1
`define FSAG_STAT_LOCK  2
`define FSAG_STAT_IRQ   6

// Lock fields: bit 0 app lower, 1 app upper, 2 boot lower, 3 boot upper
`define FSAG_LOCK_ERASED 4'hf
`define FSAG_LOCK_APPLO  0
`define FSAG_LOCK_APPHI  1
`define FSAG_LOCK_BOOTLO 2
`define FSAG_LOCK_BOOTHI 3

`endif

// File: fsag_pkg.sv
// Purpose: Types of the flash section access guard
// Assumes: fsag_consts.svh gives the widths
// Notes:   Core requests and flash commands travel as packed structs
`include "fsag_consts.svh"
package fsag_pkg;

	typedef enum logic [2:0]
	{
		FSAG_CMD_LOAD  = 3'h0,
		FSAG_CMD_BUF   = 3'h1,
		FSAG_CMD_ERASE = 3'h2,
		FSAG_CMD_WRITE = 3'h3,
		FSAG_CMD_LOCK  = 3'h4
	} fsag_cmd_t;

	typedef enum logic [1:0]
	{
		FSAG_ST_IDLE = 2'h0,
		FSAG_ST_CONC = 2'h1,
		FSAG_ST_HALT = 2'h2
	} fsag_state_t;

	typedef struct packed
	{
		logic                valid;
		fsag_cmd_t           cmd;
		logic [`FSAG_AW-1:0] addr;
		logic [3:0]          data;
	} fsag_req_t;

	typedef struct packed
	{
		logic accept;
		logic refuse;
		logic load_ok;
	} fsag_resp_t;

	typedef struct packed
	{
		logic                start;
		fsag_cmd_t           cmd;
		logic [`FSAG_AW-1:0] addr;
		logic [3:0]          data;
	} fsag_flash_t;

endpackage : fsag_pkg

// File: fsag_lock_store.sv
// Purpose: Boot lock field store, program-only between chip erases
// Assumes: Nonvolatile copy is presented on i_nv during reset
// Notes:   A zero written to a bit programs it; only erase restores ones
`timescale 1ns/1ps
`include "fsag_consts.svh"
module fsag_lock_store
	import fsag_pkg::*;
#(
	parameter int W = 4
)(
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	// Programming
	input  wire logic [W-1:0] i_nv,
	input  wire logic         i_prog,
	input  wire logic [W-1:0] i_bits,
	input  wire logic         i_erase,
	// State
	output logic      [W-1:0] o_lock_q
);

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			o_lock_q <= i_nv;
		else if (i_erase)
			o_lock_q <= {W{1'b1}};
		else if (i_prog)
			o_lock_q <= o_lock_q & i_bits;
	end

endmodule : fsag_lock_store

// File: fsag_guard.sv
// Purpose: Access guard for self-programming of program flash
// Assumes: Core requests and flash done come from logic on i_clk
// Notes:   Programming duration is set by the flash macro done pulse
//
// How it works
// - Target address of erase or write decides halting or non-halting.
// - Concurrent-region programming keeps halting-region fetches and reads running.
// - Halting-region erase or write stalls the core until done.
// - Region busy flag stays one while concurrent region reads are blocked.
// - Boot section always lies inside the halting region.
// - Two lock fields, set by software or programmer, cleared by erase.
// - General write lock does not restrict store operations.
// - General read/write lock does not restrict loads or stores.
// - Lock bits read one unprogrammed; all ones means no restriction.
// - App field mode 1 lets stores and loads reach app section.
// - App field modes 2 and 3 refuse erase and write into app section.
// - App modes 3 and 4 refuse boot-run loads from app section.
// - App modes 3, 4 with boot vectors mask interrupts in app.
// - Boot field mode 1 lets stores and loads reach boot section.
// - Boot field modes 2 and 3 refuse erase and write into boot section.
// - Boot modes 3 and 4 refuse app-run loads from boot section.
// - Boot modes 3, 4 with app vectors mask interrupts in boot.
// - Classification uses section written, not section being read.
// - Stores issued from the application section are ignored.
// - Busy clears on re-enable after programming or buffer load start.
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fsag_consts.svh"
module fsag_guard
	import fsag_pkg::*;
#(
	parameter logic [`FSAG_AW-1:0] HALT_BASE = `FSAG_HALT_BASE,
	parameter logic [`FSAG_AW-1:0] BOOT_MIN  = `FSAG_BOOT_MIN
)(
	// Clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_rst_b,
	// Core side
	input  wire fsag_req_t           i_req,
	input  wire logic [`FSAG_AW-1:0] i_pc,
	output fsag_resp_t               o_resp,
	output logic                     o_stall,
	output logic                     o_busy,
	output logic                     o_fetch_ok,
	output logic                     o_irq_off,
	// Flash macro side
	output fsag_flash_t              o_flash,
	input  wire logic                i_flash_done,
	// Fuses, nonvolatile locks and external programmer
	input  wire logic [1:0]          i_size_fuses,
	input  wire logic [3:0]          i_nv_lock,
	input  wire logic                i_ext_lock_wr,
	input  wire logic [3:0]          i_ext_lock_data,
	input  wire logic                i_chip_erase,
	// AHB-Lite slave
	input  wire logic                i_hsel,
	input  wire logic [31:0]         i_haddr,
	input  wire logic [1:0]          i_htrans,
	input  wire logic                i_hwrite,
	input  wire logic [31:0]         i_hwdata,
	input  wire logic                i_hready,
	output logic [31:0]              o_hrdata,
	output logic                     o_hreadyout,
	output logic                     o_hresp
);

	////////////////////////////////////////////////////////////////////////////
	// Section classification

	fsag_state_t         state_q;
	fsag_state_t         state_d;
	logic [3:0]          lock_q;
	logic                busy_q;
	logic                vec_boot_q;
	logic                reen_q;
	logic [`FSAG_AW-1:0] boot_size;
	logic [`FSAG_AW-1:0] boot_raw;
	logic [`FSAG_AW-1:0] boot_base;
	logic                pc_boot;
	logic                pc_halt;
	logic                tgt_boot;
	logic                tgt_halt;
	logic                app_wr_lk;
	logic                app_rd_lk;
	logic                boot_wr_lk;
	logic                boot_rd_lk;

	assign boot_size = BOOT_MIN << (~i_size_fuses);
	assign boot_raw  = {`FSAG_AW{1'b0}} - boot_size;
	// Clamp keeps odd fuse/parameter mixes out of the concurrent region
	assign boot_base = (boot_raw < HALT_BASE) ? HALT_BASE : boot_raw;
	assign pc_boot   = i_pc >= boot_base;
	assign pc_halt   = i_pc >= HALT_BASE;
	assign tgt_boot  = i_req.addr >= boot_base;
	assign tgt_halt  = i_req.addr >= HALT_BASE;
	// Lower bit zero blocks erase and write, upper bit zero blocks cross loads
	assign app_wr_lk  = !lock_q[`FSAG_LOCK_APPLO];
	assign app_rd_lk  = !lock_q[`FSAG_LOCK_APPHI];
	assign boot_wr_lk = !lock_q[`FSAG_LOCK_BOOTLO];
	assign boot_rd_lk = !lock_q[`FSAG_LOCK_BOOTHI];

	////////////////////////////////////////////////////////////////////////////
	// Request decision

	logic is_load;
	logic is_store;
	logic is_prog;
	logic store_ok;
	logic load_ok;
	logic start_prog;
	logic lock_prog;
	logic buf_start;

	assign is_load  = i_req.valid && (i_req.cmd == FSAG_CMD_LOAD);
	assign is_store = i_req.valid && (i_req.cmd != FSAG_CMD_LOAD);
	assign is_prog  = i_req.valid &&
		((i_req.cmd == FSAG_CMD_ERASE) || (i_req.cmd == FSAG_CMD_WRITE));

	// General lock modes are deliberately not consulted here
	assign store_ok = pc_boot && (state_q == FSAG_ST_IDLE) &&
		!(is_prog && (tgt_boot ? boot_wr_lk : app_wr_lk));
	assign load_ok = (state_q != FSAG_ST_HALT) &&
		!(busy_q && !tgt_halt) &&
		!(pc_boot && !tgt_boot && app_rd_lk) &&
		!(!pc_boot && tgt_boot && boot_rd_lk);
	assign start_prog = is_prog && store_ok;
	assign lock_prog  = is_store && store_ok && (i_req.cmd == FSAG_CMD_LOCK);
	assign buf_start  = is_store && store_ok && (i_req.cmd == FSAG_CMD_BUF);

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			o_resp <= '0;
		else
		begin
			o_resp.accept  <= is_store && store_ok;
			o_resp.refuse  <= (is_store && !store_ok) || (is_load && !load_ok);
			o_resp.load_ok <= is_load && load_ok;
		end
	end

	// Refused stores never reach the flash macro
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			o_flash <= '0;
		else
		begin
			o_flash.start <= is_store && store_ok;
			o_flash.cmd   <= i_req.cmd;
			o_flash.addr  <= i_req.addr;
			o_flash.data  <= i_req.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Programming sequence

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			FSAG_ST_IDLE:
			begin
				if (start_prog)
					state_d = tgt_halt ? FSAG_ST_HALT : FSAG_ST_CONC;
			end
			FSAG_ST_CONC, FSAG_ST_HALT:
			begin
				if (i_flash_done)
					state_d = FSAG_ST_IDLE;
			end
			default:
				state_d = FSAG_ST_IDLE;
		endcase
	end
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			state_q <= FSAG_ST_IDLE;
		else
			state_q <= state_d;
	end

	// Stall only for halting-region work, whole operation long
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			o_stall <= 1'b0;
		else
			o_stall <= (state_d == FSAG_ST_HALT);
	end

	// Set wins over clear; re-enable is ignored while programming runs
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			busy_q <= 1'b0;
		else if (start_prog && !tgt_halt)
			busy_q <= 1'b1;
		else if ((reen_q && (state_q == FSAG_ST_IDLE)) || buf_start)
			busy_q <= 1'b0;
	end
	assign o_busy = busy_q;

	// Fetch from the concurrent region is flagged, not stalled
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			o_fetch_ok <= 1'b1;
		else
			o_fetch_ok <= !(busy_q && !pc_halt);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			o_irq_off <= 1'b0;
		else
			o_irq_off <= (app_rd_lk && vec_boot_q && !pc_boot) ||
				(boot_rd_lk && !vec_boot_q && pc_boot);
	end

	////////////////////////////////////////////////////////////////////////////
	// Lock fields

	fsag_lock_store #(.W (4)) u_lock (
		.i_clk    (i_clk),
		.i_rst_b  (i_rst_b),
		.i_nv     (i_nv_lock),
		.i_prog   (lock_prog || i_ext_lock_wr),
		.i_bits   ((lock_prog ? i_req.data : `FSAG_LOCK_ERASED) &
			(i_ext_lock_wr ? i_ext_lock_data : `FSAG_LOCK_ERASED)),
		.i_erase  (i_chip_erase),
		.o_lock_q (lock_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, one wait state so read data comes from a flop

	logic       ahb_wait_q;
	logic       ahb_wr_q;
	logic [7:0] ahb_addr_q;
	logic       ahb_take;
	logic [31:0] rd_mux;
	assign ahb_take = !ahb_wait_q && i_hsel && i_htrans[1] && i_hready;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			ahb_wait_q  <= 1'b0;
			ahb_wr_q    <= 1'b0;
			ahb_addr_q  <= 8'h00;
			o_hreadyout <= 1'b1;
		end
		else
		begin
			ahb_wait_q  <= ahb_take;
			o_hreadyout <= !ahb_take;
			if (ahb_take)
			begin
				ahb_wr_q   <= i_hwrite;
				ahb_addr_q <= i_haddr[7:0];
			end
		end
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (ahb_addr_q == `FSAG_OFS_CTRL)
			rd_mux[`FSAG_CTRL_VECB] = vec_boot_q;
		else if (ahb_addr_q == `FSAG_OFS_STAT)
		begin
			rd_mux[`FSAG_STAT_BUSY]  = busy_q;
			rd_mux[`FSAG_STAT_STALL] = o_stall;
			rd_mux[`FSAG_STAT_LOCK +: 4] = lock_q;
			rd_mux[`FSAG_STAT_IRQ]   = o_irq_off;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			o_hrdata <= 32'h0000_0000;
		else if (ahb_wait_q && !ahb_wr_q)
			o_hrdata <= rd_mux;
	end
	assign o_hresp = 1'b0;

	// Re-enable is a one-cycle pulse; the bit itself reads back zero
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			vec_boot_q <= `FSAG_CTRL_RST;
			reen_q     <= 1'b0;
		end
		else
		begin
			reen_q <= 1'b0;
			if (ahb_wait_q && ahb_wr_q && (ahb_addr_q == `FSAG_OFS_CTRL))
			begin
				vec_boot_q <= i_hwdata[`FSAG_CTRL_VECB];
				reen_q     <= i_hwdata[`FSAG_CTRL_REEN];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// Halting work leaves the busy flag as it was
	a_halt_prog_stall: assert property (
		start_prog && tgt_halt && !reen_q |=> o_stall && o_flash.start && $stable(o_busy))
		else $error("halting program did not stall");
	a_stall_until_done: assert property (
		o_stall && !i_flash_done |=> o_stall)
		else $error("stall dropped before flash done");
	a_conc_no_stall: assert property (
		start_prog && !tgt_halt |=> !o_stall && o_busy ##1 !o_stall)
		else $error("concurrent program stalled core");
	a_busy_holds: assert property (
		o_busy && !reen_q && !buf_start |=> o_busy)
		else $error("busy flag dropped without clear");
	a_reen_clears: assert property (
		o_busy && reen_q && state_q == FSAG_ST_IDLE && !start_prog |=> !o_busy)
		else $error("re-enable did not clear busy");
	a_app_store_drop: assert property (
		is_store && !pc_boot |=> o_resp.refuse && !o_flash.start && !o_resp.accept)
		else $error("store from app section accepted");
	a_app_wr_lock: assert property (
		is_prog && pc_boot && !tgt_boot && !lock_q[`FSAG_LOCK_APPLO]
		|=> o_resp.refuse && !o_stall)
		else $error("locked app write accepted");
	a_boot_wr_lock: assert property (
		is_prog && tgt_boot && !lock_q[`FSAG_LOCK_BOOTLO] |=> !o_flash.start)
		else $error("locked boot write accepted");
	a_app_rd_lock: assert property (
		is_load && pc_boot && !tgt_boot && !lock_q[`FSAG_LOCK_APPHI]
		|=> !o_resp.load_ok && o_resp.refuse)
		else $error("locked app read allowed");
	a_boot_rd_lock: assert property (
		is_load && !pc_boot && tgt_boot && !lock_q[`FSAG_LOCK_BOOTHI] |=> !o_resp.load_ok)
		else $error("locked boot read allowed");
	a_free_mode: assert property (
		is_load && lock_q == `FSAG_LOCK_ERASED && !busy_q && state_q == FSAG_ST_IDLE
		|=> o_resp.load_ok)
		else $error("unlocked load refused");
	a_lock_sticky: assert property (
		!lock_q[0] && !i_chip_erase |=> !lock_q[0])
		else $error("lock bit cleared without erase");
	a_boot_in_halt: assert property (
		boot_base >= HALT_BASE)
		else $error("boot section outside halting region");
	a_irq_mask: assert property (
		app_rd_lk && vec_boot_q && !pc_boot |=> o_irq_off)
		else $error("interrupts not masked in app section");

	c_conc_prog: cover property (start_prog && !tgt_halt ##[1:50] i_flash_done);
	c_halt_prog: cover property (start_prog && tgt_halt ##1 o_stall);
	c_refused:   cover property (is_prog && !store_ok);
	c_reenable:  cover property (o_busy && reen_q ##1 !o_busy);

endmodule : fsag_guard

// File: fsag_flash_model.sv
// Purpose: Flash macro stand-in that ends each erase or write
// Assumes: One start pulse at a time, delay of at least one cycle
// Notes:   Done is a single-cycle pulse and low at all other times
`timescale 1ns/1ps
module fsag_flash_model
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	// Guard side
	input  wire logic       i_start,
	input  wire logic [5:0] i_dly,
	output logic            o_done
);
	logic [5:0] cnt_q;

	////////////////////////////////////////
	// Delay set per operation, so the bench can answer fast or slow
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			cnt_q  <= 6'h0;
			o_done <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			if (i_start)
				cnt_q <= i_dly;
			else if (cnt_q == 6'h1)
			begin
				o_done <= 1'b1;
				cnt_q  <= 6'h0;
			end
			else if (cnt_q != 6'h0)
				cnt_q <= cnt_q - 6'h1;
		end
	end
endmodule : fsag_flash_model

// File: fsag_guard_tb.sv
// Purpose: Self-checking bench for the flash section access guard
// Assumes: Flash model answers every start pulse
// Notes:   Lock settings are swept through reset with random fuses
`timescale 1ns/1ps
`include "fsag_consts.svh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_errors++; \
	$display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module fsag_guard_tb
	import fsag_pkg::*;
;
	logic        i_clk, i_rst_b, i_flash_done, i_ext_lock_wr, i_chip_erase;
	logic        i_hsel, i_hwrite, o_hreadyout, o_hresp, o_stall, o_busy;
	logic        o_fetch_ok, o_irq_off, vb;
	fsag_req_t   i_req;
	fsag_resp_t  o_resp, r;
	fsag_flash_t o_flash;
	logic [11:0] i_pc, bb;
	logic [1:0]  i_size_fuses, i_htrans;
	logic [3:0]  i_nv_lock, i_ext_lock_data, lk;
	logic [31:0] i_haddr, i_hwdata, o_hrdata, seed, rd;
	logic [5:0]  dly;
	int          n_errors, n_checks, v;

	fsag_guard fsag_guard_i(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req), .i_pc(i_pc),
		.o_resp(o_resp), .o_stall(o_stall), .o_busy(o_busy), .o_fetch_ok(o_fetch_ok),
		.o_irq_off(o_irq_off), .o_flash(o_flash), .i_flash_done(i_flash_done),
		.i_size_fuses(i_size_fuses), .i_nv_lock(i_nv_lock), .i_ext_lock_wr(i_ext_lock_wr),
		.i_ext_lock_data(i_ext_lock_data), .i_chip_erase(i_chip_erase), .i_hsel(i_hsel),
		.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
		.i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp));
	fsag_flash_model fsag_flash_model_i(.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_start(o_flash.start), .i_dly(dly), .o_done(i_flash_done));

	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Boot section sits at the top of flash
	function automatic logic [11:0] boot_base(input logic [1:0] f);
		return 12'h000 - (12'h080 << ~f);
	endfunction : boot_base

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task automatic rst(input logic [3:0] nv);
		logic [1:0] f;
		f = 2'(rnd());
		bb = boot_base(f);
		@(posedge i_clk);
		i_rst_b      <= 1'b0;
		i_nv_lock    <= nv;
		i_size_fuses <= f;
		dly          <= 6'(1 + rnd() % 20);
		repeat (6) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
		#1;
		`CHK("reset stall", 1'b0, o_stall)
		`CHK("reset fetch", 1'b1, o_fetch_ok)
	endtask : rst

	task automatic op(input fsag_cmd_t c, input logic [11:0] a, input logic [11:0] pc,
		input logic [3:0] d, input logic acc, input logic rf, input logic lok);
		@(posedge i_clk);
		i_req <= '{1'b1, c, a, d};
		i_pc  <= pc;
		@(posedge i_clk);
		i_req.valid <= 1'b0;
		#1;
		r = o_resp;
		`CHK("accept", acc, r.accept)
		`CHK("refuse", rf, r.refuse)
		`CHK("load ok", lok, r.load_ok)
		if (c inside {FSAG_CMD_ERASE, FSAG_CMD_WRITE})
		begin
			`CHK("start", acc, o_flash.start)
			`CHK("flash addr", a, o_flash.addr)
			`CHK("flash cmd", c, o_flash.cmd)
		end
		if (rf)
			`CHK("refused stall", 1'b0, o_stall)
	endtask : op

	// Stall must hold its level until the done pulse, then drop
	task automatic run_out(input logic halt);
		int n;
		for (n = 0; n < 100; n++)
		begin
			`CHK("stall", halt, o_stall)
			if (i_flash_done === 1'b1)
				break;
			@(posedge i_clk);
			#1;
		end
		if (n == 100)
		begin
			n_errors++;
			close_out();
		end
		@(posedge i_clk);
		#1;
		`CHK("stall end", 1'b0, o_stall)
	endtask : run_out

	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_hreadyout !== 1'b1 && n < 50);
		if (o_hreadyout !== 1'b1)
		begin
			n_errors++;
			close_out();
		end
	endtask : wait_rdy

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge i_clk);
		i_hsel   <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr  <= {24'h0, a};
		i_hwrite <= w;
		wait_rdy();
		i_hsel   <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		wait_rdy();
		rd = o_hrdata;
		`CHK("bus resp", 1'b0, o_hresp)
	endtask : bus

	task automatic chk_irq(input logic [11:0] pc, input logic ex);
		@(posedge i_clk);
		i_pc <= pc;
		repeat (3) @(posedge i_clk);
		#1;
		`CHK("irq off", ex, o_irq_off)
	endtask : chk_irq

	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : settle

	////////////////////////////////////////
	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	initial
	begin
		{i_rst_b, i_hsel, i_hwrite, i_ext_lock_wr, i_chip_erase} = '0;
		{i_req, i_pc, i_size_fuses, i_haddr, i_hwdata, i_htrans} = '0;
		{i_nv_lock, i_ext_lock_data} = 8'hff;
		{n_errors, n_checks} = '0;
		seed = 32'h35;
		dly  = 6'h1;
		for (v = 0; v < 16; v++)
		begin
			lk = 4'(v);
			rst(lk);
			bus(1'b0, 8'h04, 32'h0);
			`CHK("lock bits", lk, rd[5:2])
			bus(1'b0, 8'h08, 32'h0);
			`CHK("unmapped", 32'h0, rd)
			vb = 1'(rnd());
			bus(1'b1, 8'h00, {30'h0, vb, 1'b0});
			bus(1'b0, 8'h00, 32'h0);
			`CHK("ctrl read", {30'h0, vb, 1'b0}, rd)
			chk_irq(12'h100, vb & ~lk[1]);
			chk_irq(bb, ~vb & ~lk[3]);
			op(FSAG_CMD_LOAD, 12'h010, bb, 4'h0, 1'b0, ~lk[1], lk[1]);
			op(FSAG_CMD_LOAD, bb + 12'h8, 12'h100, 4'h0, 1'b0, ~lk[3], lk[3]);
			op(FSAG_CMD_WRITE, 12'h020, bb - 12'h1, 4'h0, 1'b0, 1'b1, 1'b0);
			op(FSAG_CMD_ERASE, bb, bb, 4'h0, lk[2], ~lk[2], 1'b0);
			if (lk[2])
				run_out(1'b1);
			op(FSAG_CMD_WRITE, 12'h020, bb, 4'h0, lk[0], ~lk[0], 1'b0);
			if (lk[0])
				run_out(1'b0);
			$display("lock sweep step %0d done", v);
		end
		rst(4'hf);
		dly <= 6'd40;
		op(FSAG_CMD_ERASE, 12'h040, bb, 4'h0, 1'b1, 1'b0, 1'b0);
		`CHK("busy set", 1'b1, o_busy)
		`CHK("no halt", 1'b0, o_stall)
		op(FSAG_CMD_LOAD, 12'hff8, 12'h100, 4'h0, 1'b0, 1'b0, 1'b1);
		`CHK("fetch blocked", 1'b0, o_fetch_ok)
		op(FSAG_CMD_LOAD, 12'h040, bb, 4'h0, 1'b0, 1'b1, 1'b0);
		op(FSAG_CMD_WRITE, 12'hc40, bb, 4'h0, 1'b0, 1'b1, 1'b0);
		bus(1'b1, 8'h00, 32'h1);
		settle(2);
		`CHK("reen ignored", 1'b1, o_busy)
		run_out(1'b0);
		`CHK("busy kept", 1'b1, o_busy)
		bus(1'b0, 8'h04, 32'h0);
		`CHK("busy bit", 1'b1, rd[0])
		dly <= 6'd5;
		op(FSAG_CMD_BUF, 12'h040, bb, 4'h0, 1'b1, 1'b0, 1'b0);
		settle(2);
		`CHK("buf clears", 1'b0, o_busy)
		settle(10);
		op(FSAG_CMD_ERASE, 12'h040, bb, 4'h0, 1'b1, 1'b0, 1'b0);
		run_out(1'b0);
		bus(1'b1, 8'h00, 32'h1);
		settle(2);
		`CHK("busy cleared", 1'b0, o_busy)
		op(FSAG_CMD_LOAD, 12'h040, 12'h100, 4'h0, 1'b0, 1'b0, 1'b1);
		$display("busy flag test done");
		rst(4'hf);
		@(posedge i_clk);
		i_ext_lock_wr   <= 1'b1;
		i_ext_lock_data <= 4'h9;
		@(posedge i_clk);
		i_ext_lock_wr <= 1'b0;
		op(FSAG_CMD_LOCK, 12'h0, bb, 4'he, 1'b1, 1'b0, 1'b0);
		settle(30);
		op(FSAG_CMD_LOCK, 12'h0, bb, 4'hf, 1'b1, 1'b0, 1'b0);
		settle(30);
		bus(1'b0, 8'h04, 32'h0);
		`CHK("locks set", 4'h8, rd[5:2])
		@(posedge i_clk);
		i_chip_erase <= 1'b1;
		@(posedge i_clk);
		i_chip_erase <= 1'b0;
		bus(1'b0, 8'h04, 32'h0);
		`CHK("locks erased", 4'hf, rd[5:2])
		$display("lock store test done");
		close_out();
	end
endmodule : fsag_guard_tb
